// ---- rtl/smc_consts.vh ----
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define SMC_ADDR_W          8
`define SMC_ADDR_SYSCTRL    8'h00
`define SMC_ADDR_STATUS     8'h04

// ----------------------------------------
// system control register fields
// ----------------------------------------
`define SMC_BIT_HALT_DEEP_SLEEP_PIN   7
`define SMC_SEL_HI          6
`define SMC_SEL_LO          4
`define SMC_BIT_INIT_SRC    3
`define SMC_BIT_EDGE_SEL    2
`define SMC_BIT_SPARE       1
`define SMC_BIT_MEM_EN      0
`define SMC_SYSCTRL_RST     8'h09

// ----------------------------------------
// status register fields
// ----------------------------------------
`define SMC_ST_STATE_HI     2
`define SMC_ST_BUSY         3
`define SMC_ST_INIT_PIN     4
`define SMC_ST_SLEEP_PIN    5
`define SMC_ST_URGENT_PIN   6

// ----------------------------------------
// wake sources and settling
// ----------------------------------------
`define SMC_IRQ_WAKE_MASK   8'h47
`define SMC_SETTLE_BASE     8192
`define SMC_SETTLE_CNT_W    18
`define SMC_SEL_MAX_SHIFT   3'h4

`endif

// ---- rtl/smc_pin_sync.v ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// three-stage pin synchroniser
// ----------------------------------------
module smc_pin_sync #(
    parameter             WIDTH = 1,
    parameter [WIDTH-1:0] INIT  = {WIDTH{1'b1}}
) (
    input  wire             clk_sys,
    input  wire             rst,
    input  wire [WIDTH-1:0] pin_async,
    output wire [WIDTH-1:0] pin_sync
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg s1_r;
            reg s2_r;
            reg s3_r;
            reg out_r;
            // out only moves when stages two and three agree, filtering a late flip
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    s1_r  <= INIT[i];
                    s2_r  <= INIT[i];
                    s3_r  <= INIT[i];
                    out_r <= INIT[i];
                end else begin
                    s1_r <= pin_async[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        out_r <= s3_r;
                    end
                end
            end
            assign pin_sync[i] = out_r;
        end
    endgenerate

endmodule

`default_nettype wire

// ---- rtl/smc_settle_timer.v ----
`include "smc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// oscillator settling counter
// ----------------------------------------
module smc_settle_timer #(
    parameter CNT_W       = `SMC_SETTLE_CNT_W,
    parameter SETTLE_BASE = `SMC_SETTLE_BASE
) (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       start,
    input  wire       abort,
    input  wire [2:0] sel,
    output reg        busy,
    output reg        done
);

    reg  [CNT_W-1:0] cnt_r;
    reg  [CNT_W-1:0] last_r;
    wire [2:0]       shift;

    // 10x and the prohibited 11x both give the longest count
    assign shift   = sel[2] ? `SMC_SEL_MAX_SHIFT : {1'b0, sel[1:0]};

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r  <= {CNT_W{1'b0}};
            last_r <= {CNT_W{1'b0}};
            busy   <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy  <= 1'b0;
                cnt_r <= {CNT_W{1'b0}};
            end else if (start) begin
                busy   <= 1'b1;
                cnt_r  <= {CNT_W{1'b0}};
                last_r <= (SETTLE_BASE[CNT_W-1:0] << shift) - {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (busy) begin
                if (cnt_r == last_r) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

`default_nettype wire

// ---- rtl/smc_standby_ctrl.v ----
// Summary of operation
// - urgent or irq 0,1,2,6 restarts oscillator
// - after settle: release clock, run irq handling
// - select gives 8192 up to 131072 states
// - init pin low starts osc; rise resets
// - deep sleep low in standby: hardware standby
// - edge select: 0 falling, 1 rising
// - rising select wakes on next rising edge
// - ports hold their outputs in software standby
// - deep sleep low: hardware standby from anywhere
// - hardware standby: halt, reset, ports hi-z
// - deep sleep rise restarts osc, init low
// - init pin rise after standby: reset sequence
// - select field bits 6:4; 11x prohibited
// - halt-standby bit survives interrupt wake
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`include "smc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module smc_standby_ctrl #(
    parameter SETTLE_BASE = `SMC_SETTLE_BASE
) (
    input  wire                   clk_sys,
    input  wire                   rst,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`SMC_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    output reg  [31:0]            prdata,
    output wire                   pready,
    output wire                   pslverr,
    input  wire                   halt_exec,
    input  wire                   hard_init_pin_n,
    input  wire                   deep_sleep_pin_n,
    input  wire                   urgent_wake_pin,
    input  wire [7:0]             ext_irq_n,
    output reg                    osc_run,
    output reg                    clk_release,
    output reg                    cpu_halt,
    output reg                    periph_reset,
    output reg                    io_hold,
    output reg                    io_hiz,
    output wire                   onchip_memory_enable,
    output reg                    wake_exc_start,
    output reg                    reset_exc_start,
    output reg                    sw_standby_active,
    output reg                    hw_standby_active
);

    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [2:0] ST_RUN    = 3'h0;
    localparam [2:0] ST_SWSTBY = 3'h1;
    localparam [2:0] ST_SETTLE = 3'h2;
    localparam [2:0] ST_INIT   = 3'h3;
    localparam [2:0] ST_HWSTBY = 3'h4;

    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [7:0]  sysctrl_r;
    reg         urgent_prev_r;
    reg         init_prev_r;
    reg         settle_start;
    reg         restore_defaults;
    wire        init_sync;
    wire        sleep_sync;
    wire        urgent_sync;
    wire [7:0]  irq_sync;
    wire        settle_busy;
    wire        settle_done;
    wire        urgent_edge;
    wire        irq_wake;
    wire        init_rise;
    wire        halt_deep_sleep_pin;
    wire        edge_sel;
    wire [2:0]  settle_sel;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    smc_pin_sync #(
        .WIDTH (11),
        .INIT  (11'h7FF)
    ) u_sync (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .pin_async ({hard_init_pin_n, deep_sleep_pin_n, urgent_wake_pin, ext_irq_n}),
        .pin_sync  ({init_sync, sleep_sync, urgent_sync, irq_sync})
    );

    // ----------------------------------------
    // settle counter
    // ----------------------------------------
    smc_settle_timer #(
        .CNT_W       (`SMC_SETTLE_CNT_W),
        .SETTLE_BASE (SETTLE_BASE)
    ) u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (settle_start),
        .abort   (state_nxt != ST_SETTLE),
        .sel     (settle_sel),
        .busy    (settle_busy),
        .done    (settle_done)
    );

    // ----------------------------------------
    // register fields
    // ----------------------------------------
    assign halt_deep_sleep_pin            = sysctrl_r[`SMC_BIT_HALT_DEEP_SLEEP_PIN];
    assign settle_sel           = sysctrl_r[`SMC_SEL_HI:`SMC_SEL_LO];
    assign edge_sel             = sysctrl_r[`SMC_BIT_EDGE_SEL];
    assign onchip_memory_enable = sysctrl_r[`SMC_BIT_MEM_EN];

    // ----------------------------------------
    // wake event detection
    // ----------------------------------------
    // edge polarity follows the select bit; change it before entry, not during standby
    assign urgent_edge = edge_sel ? (urgent_sync & ~urgent_prev_r)
                                  : (~urgent_sync & urgent_prev_r);
    // irq 3-5 and 7 never wake: software is expected to have disabled them
    assign irq_wake    = |(~irq_sync & `SMC_IRQ_WAKE_MASK);
    assign init_rise   = init_sync & ~init_prev_r;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            urgent_prev_r <= 1'b1;
            init_prev_r   <= 1'b1;
        end else begin
            urgent_prev_r <= urgent_sync;
            init_prev_r   <= init_sync;
        end
    end

    // ----------------------------------------
    // mode sequencer
    // ----------------------------------------
    always @* begin
        state_nxt        = state_r;
        settle_start     = 1'b0;
        restore_defaults = 1'b0;
        if (!sleep_sync) begin
            state_nxt = ST_HWSTBY;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (!init_sync) begin
                        state_nxt = ST_INIT;
                    end else if (halt_exec && halt_deep_sleep_pin) begin
                        state_nxt = ST_SWSTBY;
                    end
                end
                ST_SWSTBY: begin
                    if (!init_sync) begin
                        state_nxt = ST_INIT;
                    end else if (urgent_edge || irq_wake) begin
                        state_nxt    = ST_SETTLE;
                        settle_start = 1'b1;
                    end
                end
                ST_SETTLE: begin
                    if (!init_sync) begin
                        state_nxt = ST_INIT;
                    end else if (settle_done) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_INIT: begin
                    // oscillator runs here; partner owns the settling time
                    if (init_rise) begin
                        state_nxt        = ST_RUN;
                        restore_defaults = 1'b1;
                    end
                end
                ST_HWSTBY: begin
                    state_nxt = ST_INIT;
                end
                default: begin
                    state_nxt = ST_RUN;
                end
            endcase
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------
    // output decode
    // ----------------------------------------
    reg         osc_run_nxt;
    reg         clk_release_nxt;
    reg         cpu_halt_nxt;
    reg         periph_reset_nxt;
    reg         io_hold_nxt;
    reg         io_hiz_nxt;
    reg         sw_deep_sleep_pin_nxt;
    reg         hw_deep_sleep_pin_nxt;

    // decoded from the next state so each output moves on the edge that enters it
    always @* begin
        osc_run_nxt      = 1'b1;
        clk_release_nxt  = 1'b0;
        cpu_halt_nxt     = 1'b1;
        periph_reset_nxt = 1'b1;
        io_hold_nxt      = 1'b0;
        io_hiz_nxt       = 1'b0;
        sw_deep_sleep_pin_nxt      = 1'b0;
        hw_deep_sleep_pin_nxt      = 1'b0;
        case (state_nxt)
            ST_RUN: begin
                // only state with the chip clock supplied
                clk_release_nxt  = 1'b1;
                cpu_halt_nxt     = 1'b0;
                periph_reset_nxt = 1'b0;
            end
            ST_SWSTBY: begin
                // clock stopped but pins keep their levels
                osc_run_nxt = 1'b0;
                io_hold_nxt = 1'b1;
                sw_deep_sleep_pin_nxt = 1'b1;
            end
            ST_SETTLE: begin
                // oscillator runs, chip clock withheld until the count ends
                periph_reset_nxt = 1'b0;
                io_hold_nxt      = 1'b1;
                sw_deep_sleep_pin_nxt      = 1'b1;
            end
            ST_INIT: begin
                // oscillator runs with everything held in reset
                osc_run_nxt = 1'b1;
            end
            ST_HWSTBY: begin
                // pins float, only on-chip memory keeps its contents
                osc_run_nxt = 1'b0;
                io_hiz_nxt  = 1'b1;
                hw_deep_sleep_pin_nxt = 1'b1;
            end
            default: begin
                // unused codes: hold everything in reset
                periph_reset_nxt = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // registered controls
    // ----------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            osc_run           <= 1'b1;
            clk_release       <= 1'b1;
            cpu_halt          <= 1'b0;
            periph_reset      <= 1'b0;
            io_hold           <= 1'b0;
            io_hiz            <= 1'b0;
            wake_exc_start    <= 1'b0;
            reset_exc_start   <= 1'b0;
            sw_standby_active <= 1'b0;
            hw_standby_active <= 1'b0;
        end else begin
            osc_run           <= osc_run_nxt;
            clk_release       <= clk_release_nxt;
            cpu_halt          <= cpu_halt_nxt;
            periph_reset      <= periph_reset_nxt;
            io_hold           <= io_hold_nxt;
            io_hiz            <= io_hiz_nxt;
            wake_exc_start    <= (state_r == ST_SETTLE) && (state_nxt == ST_RUN);
            reset_exc_start   <= restore_defaults;
            sw_standby_active <= sw_deep_sleep_pin_nxt;
            hw_standby_active <= hw_deep_sleep_pin_nxt;
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    wire        apb_access;
    wire        hit_ctrl;
    wire        hit_stat;
    wire [31:0] stat_word;

    // zero wait states keeps the master simple; unmapped reads give zero
    assign pready     = 1'b1;
    assign hit_ctrl   = (paddr == `SMC_ADDR_SYSCTRL);
    assign hit_stat   = (paddr == `SMC_ADDR_STATUS);
    assign apb_access = psel & penable;
    assign pslverr    = apb_access & ~(hit_ctrl | hit_stat);

    assign stat_word = {25'h0000000, urgent_sync, sleep_sync, init_sync, settle_busy, state_r};

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            if (hit_ctrl) begin
                prdata <= {24'h000000, sysctrl_r};
            end else if (hit_stat) begin
                prdata <= stat_word;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // system control register
    // ----------------------------------------
    // held at its defaults through hardware standby and reloaded on reset exit
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sysctrl_r <= `SMC_SYSCTRL_RST;
        end else if ((state_r == ST_HWSTBY) || restore_defaults) begin
            sysctrl_r <= `SMC_SYSCTRL_RST;
        end else if (apb_access && pwrite && hit_ctrl) begin
            sysctrl_r                     <= pwdata[7:0];
            sysctrl_r[`SMC_BIT_INIT_SRC]  <= 1'b1;
            if (pwdata[`SMC_SEL_HI] && pwdata[`SMC_SEL_HI-1]) begin
                // prohibited code: keep the longest legal setting instead
                sysctrl_r[`SMC_SEL_HI:`SMC_SEL_LO] <= 3'h4;
            end
        end
    end

endmodule

`default_nettype wire

// ---- tb/smc_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external system on the pins
// ----------------------------------------
module smc_pin_model (
    input  wire logic       clk_sys,
    output var  logic       hard_init_pin_n,
    output var  logic       deep_sleep_pin_n,
    output var  logic       urgent_wake_pin,
    output var  logic [7:0] ext_irq_n
);
    logic [1:0] boot_sel_r;
    initial begin
        hard_init_pin_n = 1'b1;
        deep_sleep_pin_n = 1'b1;
        urgent_wake_pin = 1'b1;
        ext_irq_n = 8'hFF;
        boot_sel_r = 2'h3;  // boot select held steady, never both low
    end
    // id 0..7 irq, 8 urgent, 9 init, other deep sleep
    task drive(input int id, input logic v);
        begin
            @(posedge clk_sys);
            if (id < 8)
                ext_irq_n[id] <= v;
            else if (id == 8)
                urgent_wake_pin <= v;
            else if (id == 9)
                hard_init_pin_n <= v;
            else
                deep_sleep_pin_n <= v;
        end
    endtask
    // init stays low while the oscillator settles, device does not time it
    task leave_hw(input int settle);
        begin
            drive(9, 1'b0);
            drive(10, 1'b1);
            repeat (settle) @(posedge clk_sys);
            drive(9, 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/smc_standby_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// sequencer checker
// ----------------------------------------
module smc_standby_props #(
    parameter SETTLE_BASE = 16
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       deep_sleep_pin_n,
    input wire logic [7:0] ext_irq_n,
    input wire logic       osc_run,
    input wire logic       clk_release,
    input wire logic       cpu_halt,
    input wire logic       periph_reset,
    input wire logic       io_hold,
    input wire logic       io_hiz,
    input wire logic       onchip_memory_enable,
    input wire logic       wake_exc_start,
    input wire logic       reset_exc_start,
    input wire logic       sw_standby_active
);
    // settle cycles seen at the ports, cleared outside standby
    logic [19:0] settle_r;
    always @(posedge clk_sys or posedge rst) begin
        if (rst)
            settle_r <= 20'h00000;
        else if (sw_standby_active && osc_run)
            settle_r <= settle_r + 20'h00001;
        else
            settle_r <= 20'h00000;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_settle_len: assert property ($rose(clk_release) && $past(sw_standby_active) |->
        settle_r >= SETTLE_BASE && settle_r <= 16 * SETTLE_BASE + 8) else $error("settle length off");
    a_wake_run: assert property (wake_exc_start |-> clk_release && !cpu_halt && !io_hold)
        else $error("wake start outside run");
    a_wake_pulse: assert property (wake_exc_start |=> !wake_exc_start) else $error("wake pulse long");
    a_irq_osc: assert property (sw_standby_active && !osc_run && !ext_irq_n[0] && deep_sleep_pin_n
        |-> ##[1:8] osc_run) else $error("irq did not start oscillator");
    a_port_hold: assert property (sw_standby_active |-> io_hold && !io_hiz && cpu_halt)
        else $error("ports not held");
    a_sleep_hiz: assert property (!deep_sleep_pin_n [*6] |-> ##[0:3] io_hiz) else $error("no hw standby");
    a_hiz_halt: assert property (io_hiz |-> cpu_halt && periph_reset && !clk_release && !osc_run)
        else $error("hw standby not halted");
    a_hiz_mem: assert property (io_hiz && $past(io_hiz) |-> onchip_memory_enable)
        else $error("control not reset");
    a_init_exit: assert property (reset_exc_start |-> clk_release && !periph_reset && !io_hiz)
        else $error("reset start outside run");
endmodule
bind smc_standby_ctrl smc_standby_props #(.SETTLE_BASE(SETTLE_BASE)) u_props (
    .clk_sys(clk_sys), .rst(rst), .deep_sleep_pin_n(deep_sleep_pin_n), .ext_irq_n(ext_irq_n),
    .osc_run(osc_run), .clk_release(clk_release), .cpu_halt(cpu_halt), .periph_reset(periph_reset),
    .io_hold(io_hold), .io_hiz(io_hiz), .onchip_memory_enable(onchip_memory_enable),
    .wake_exc_start(wake_exc_start), .reset_exc_start(reset_exc_start), .sw_standby_active(sw_standby_active));
`default_nettype wire

// ---- tb/test_standby_mode_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_standby_mode_controller;
    localparam SB = 16;
    logic        clk_sys, rst, psel, penable, pwrite, halt_exec, last_err;
    logic [7:0]  paddr, ext_irq_n;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, hard_init_pin_n, deep_sleep_pin_n, urgent_wake_pin;
    wire         osc_run, clk_release, cpu_halt, periph_reset, io_hold, io_hiz, onchip_memory_enable;
    wire         wake_exc_start, reset_exc_start, sw_standby_active, hw_standby_active;
    int          num_errors, n_checks, cyc;
    smc_standby_ctrl #(.SETTLE_BASE(SB)) uut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec),
        .hard_init_pin_n(hard_init_pin_n), .deep_sleep_pin_n(deep_sleep_pin_n),
        .urgent_wake_pin(urgent_wake_pin), .ext_irq_n(ext_irq_n), .osc_run(osc_run),
        .clk_release(clk_release), .cpu_halt(cpu_halt), .periph_reset(periph_reset), .io_hold(io_hold),
        .io_hiz(io_hiz), .onchip_memory_enable(onchip_memory_enable), .wake_exc_start(wake_exc_start),
        .reset_exc_start(reset_exc_start), .sw_standby_active(sw_standby_active),
        .hw_standby_active(hw_standby_active));
    smc_pin_model u_pins (.clk_sys(clk_sys), .hard_init_pin_n(hard_init_pin_n),
        .deep_sleep_pin_n(deep_sleep_pin_n), .urgent_wake_pin(urgent_wake_pin), .ext_irq_n(ext_irq_n));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task chk(input bit ok, input string msg);
        begin
            n_checks++;
            if (!ok) begin
                num_errors++;
                $display("BAD %0t %s", $time, msg);
            end
        end
    endtask
    // setup, then access held until pready is seen high
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        begin
            @(posedge clk_sys);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            do begin
                @(posedge clk_sys);
            end while (pready !== 1'b1);
            rd = prdata;
            last_err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task go_standby(input logic [31:0] ctl);
        begin
            apb(8'h00, 1'b1, ctl);
            @(posedge clk_sys);
            halt_exec <= 1'b1;
            @(posedge clk_sys);
            halt_exec <= 1'b0;
            repeat (4) @(posedge clk_sys);
            chk(sw_standby_active === 1'b1 && io_hold === 1'b1 && clk_release === 1'b0, "no standby");
        end
    endtask
    // src 0..7 irq line, 8 urgent falling, 9 urgent rising
    task wake_test(input logic [2:0] sel, input int shf, input int src);
        int n;
        begin
            u_pins.drive(8, src != 9);
            go_standby({24'h000000, 1'b1, sel, 1'b1, src == 9, 2'h1});
            u_pins.drive(3, 1'b0);
            repeat (10) @(posedge clk_sys);
            chk(sw_standby_active === 1'b1 && osc_run === 1'b0, "masked irq woke");
            u_pins.drive(3, 1'b1);
            u_pins.drive(src < 8 ? src : 8, src == 9);
            n = 0;
            while (wake_exc_start !== 1'b1 && n < 600) begin
                @(posedge clk_sys);
                n++;
            end
            chk(n >= (SB << shf) && n <= (SB << shf) + 12, "settle count");
            chk(clk_release === 1'b1 && cpu_halt === 1'b0, "no release");
            if (src < 8) u_pins.drive(src, 1'b1);
            apb(8'h00, 1'b0, 32'h0);
            chk(rd[7] === 1'b1 && rd[6:4] === (sel[2] ? 3'h4 : sel), "control after wake");
            $display("wake test %0d done", src);
        end
    endtask
    // mode 0 from run, 1 from standby init first, 2 from standby deep sleep first
    task hw_test(input int mode);
        int n;
        begin
            if (mode != 0) go_standby(32'h00000088);  // memory enable off first
            else apb(8'h00, 1'b1, 32'h00000088);
            @(posedge clk_sys);
            chk(onchip_memory_enable === 1'b0, "memory enable not cleared");
            if (mode != 2) begin
                u_pins.drive(9, 1'b0);  // init first
                repeat (8) @(posedge clk_sys);
                chk(osc_run === 1'b1 && periph_reset === 1'b1, "init low");
            end
            u_pins.drive(10, 1'b0);
            repeat (8) @(posedge clk_sys);
            chk(io_hiz === 1'b1 && hw_standby_active === 1'b1 && cpu_halt === 1'b1, "no hw standby");
            apb(8'h00, 1'b1, 32'h000000F6);
            apb(8'h00, 1'b0, 32'h0);
            chk(rd === 32'h00000009, "control in hw standby");
            apb(8'h04, 1'b0, 32'h0);
            chk(rd[2:0] === 3'h4 && rd[5] === 1'b0, "status in hw standby");
            u_pins.leave_hw(20);
            n = 0;
            while (reset_exc_start !== 1'b1 && n < 20) begin
                @(posedge clk_sys);
                n++;
            end
            chk(n < 20 && clk_release === 1'b1, "no reset exit");
            $display("hw test %0d done", mode);
        end
    endtask
    task report_and_stop();
        begin
            $display("checks %0d errors %0d", n_checks, num_errors);
            if (num_errors == 0 && n_checks > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, halt_exec, last_err} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        apb(8'h00, 1'b0, 32'h0);
        chk(rd === 32'h00000009, "control reset value");
        apb(8'h08, 1'b0, 32'h0);
        chk(last_err === 1'b1 && rd === 32'h0, "unmapped read");
        apb(8'h00, 1'b1, 32'h000000FF);
        apb(8'h00, 1'b0, 32'h0);
        chk(rd === 32'h000000CF, "prohibited select");
        wake_test(3'h0, 0, 0);
        wake_test(3'h1, 1, 1);
        wake_test(3'h2, 2, 2);
        wake_test(3'h3, 3, 6);
        wake_test(3'h4, 4, 8);
        wake_test(3'h6, 4, 9);
        hw_test(0);
        hw_test(1);
        hw_test(2);
        report_and_stop();
    end
endmodule
`default_nettype wire
